// ### shared/sapg_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 100 MHz system clock and a 32-bit apb register bus
`ifndef SAPG_REGS_SVH
`define SAPG_REGS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define SAPG_CTRL_OFS      12'h000
`define SAPG_STATUS_OFS    12'h004
`define SAPG_COUNT_OFS     12'h008

// ----------------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------------
`define SAPG_CTRL_MODE_BIT    0
`define SAPG_CTRL_PSEUDO_BIT  1
`define SAPG_CTRL_GAIN_LSB    2
`define SAPG_CTRL_TWOCH_BIT   5
`define SAPG_CTRL_PGAOUT_BIT  6
`define SAPG_CTRL_PGAPON_BIT  7
`define SAPG_CTRL_VREF_LSB    8
`define SAPG_CTRL_PDSEL_LSB   10
`define SAPG_CTRL_FAST_BIT    16
`define SAPG_CTRL_CLK_LSB     17
`define SAPG_CTRL_WIDTH       19
`define SAPG_CTRL_RESET       19'h0_0000

// ----------------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------------
`define SAPG_STAT_RESULT_LSB  0
`define SAPG_STAT_POWER_BIT   8
`define SAPG_STAT_RUN_BIT     9
`define SAPG_STAT_MACRO_BIT   10
`define SAPG_STAT_BADGAIN_BIT 11

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SAPG_CLK_NS        10
`define SAPG_SLOW_PON_US   500
`define SAPG_FAST_PON_US   5
`define SAPG_SLOW_PON_CYC  ((`SAPG_SLOW_PON_US * 1000) / `SAPG_CLK_NS)
`define SAPG_FAST_PON_CYC  ((`SAPG_FAST_PON_US * 1000) / `SAPG_CLK_NS)
`define SAPG_CONV_TICKS    16
`define SAPG_SAMPLE_END    4'h1
`define SAPG_SAR_FIRST     4'h2
`define SAPG_SAR_LAST      4'h9
`define SAPG_SER_FIRST     4'h6
`define SAPG_SER_LAST      4'hD
`define SAPG_PAR_TICK      4'hA

`endif

// ### shared/sapg_pkg.sv
// types shared by the converter control block
// assumes sapg_regs.svh supplies the field layout
`default_nettype none
package sapg_pkg;

  typedef struct packed {
    logic [1:0] clkSel;
    logic       fastPon;
    logic [5:0] pdSel;
    logic [1:0] vrefSel;
    logic       pgaPowerOn;
    logic       pgaOutEn;
    logic       twoChanEn;
    logic [2:0] gain;
    logic       pseudoEn;
    logic       inputMode;
  } sapg_cfg_type;

  typedef struct packed {
    logic       diffMode;
    logic       pseudoMode;
    logic [2:0] gain;
    logic       posInFirst;
    logic       pgaPower;
    logic       pgaOutRoute;
    logic       outRefEn;
    logic [1:0] vrefSel;
    logic [1:0] clkSel;
    logic       macroPower;
    logic       adcPower;
    logic       sampleHold;
    logic [7:0] dacTrial;
  } sapg_ana_type;

  typedef enum logic [1:0] {PWR_OFF, PWR_WARM, PWR_RUN} sapg_pwr_type;

  typedef struct packed {
    logic [69:0]  sync1;
    logic [69:0]  sync2;
    sapg_cfg_type cfg;
    sapg_ana_type ana;
    sapg_pwr_type pwr;
    logic [15:0]  waitCnt;
    logic [3:0]   tick;
    logic         prevClk;
    logic         macroOn;
    logic [7:0]   sar;
    logic [7:0]   parallel;
    logic         serial;
    logic         done;
    logic [15:0]  convCount;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
  } sapg_state_type;

endpackage
`default_nettype wire

// ### rtl/sapg_adc_ctrl.sv
// control of an 8-bit sar converter and its gain front end
// assumes apb master on clk; pins and oscillators arrive asynchronously
`default_nettype none
`include "sapg_regs.svh"
module sapg_adc_ctrl #(
  parameter int SLOW_PON_CYC = `SAPG_SLOW_PON_CYC,
  parameter int FAST_PON_CYC = `SAPG_FAST_PON_CYC
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // asynchronous inputs
  input  wire logic [63:0]   routedSignals,
  input  wire logic          ringOsc,
  input  wire logic          routed_external_clock,
  input  wire logic          rcOsc,
  input  wire logic          spiClk,
  input  wire logic          channel_pin_select,
  input  wire logic          analog_comparator,
  // analog control
  output sapg_pkg::sapg_ana_type anaCtrl,
  // results
  output logic               serial_result,
  output logic      [7:0]    parallel_result,
  output logic               convDone
);

  // --------------------------------------------------------------------------
  // parameter check
  // --------------------------------------------------------------------------
  if (SLOW_PON_CYC < 1 || SLOW_PON_CYC > 65535 || FAST_PON_CYC < 1 || FAST_PON_CYC > 65535) begin : g_bad
    $error("power-on counts out of range");
  end

  localparam logic [15:0] SLOW_CNT = 16'(SLOW_PON_CYC - 1);
  localparam logic [15:0] FAST_CNT = 16'(FAST_PON_CYC - 1);

  sapg_pkg::sapg_state_type st_r;
  sapg_pkg::sapg_state_type st_nxt;

  // --------------------------------------------------------------------------
  // derived signals
  // --------------------------------------------------------------------------
  logic        pdSig;
  logic        convClk;
  logic        tickEdge;
  logic        chanPin;
  logic        compBit;
  logic        apbAccess;
  logic        badGain;
  logic [31:0] readData;
  logic        unmapped;

  always_comb begin
    pdSig   = st_r.sync2[st_r.cfg.pdSel];
    convClk = st_r.sync2[64 + {30'h0000_0000, st_r.cfg.clkSel}];
    chanPin = st_r.sync2[68];
    compBit = st_r.sync2[69];
    tickEdge = convClk & ~st_r.prevClk;
    apbAccess = psel & penable;
    if (!st_r.cfg.inputMode) begin
      badGain = (st_r.cfg.gain > 3'h4);
    end else if (st_r.cfg.pseudoEn) begin
      badGain = (st_r.cfg.gain > 3'h1);
    end else begin
      badGain = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // register read decode
  // --------------------------------------------------------------------------
  always_comb begin
    readData = 32'h0000_0000;
    unmapped = 1'b0;
    if (paddr == `SAPG_CTRL_OFS) begin
      readData[`SAPG_CTRL_WIDTH-1:0] = st_r.cfg;
    end else if (paddr == `SAPG_STATUS_OFS) begin
      readData[`SAPG_STAT_RESULT_LSB +: 8] = st_r.parallel;
      readData[`SAPG_STAT_POWER_BIT]       = st_r.ana.adcPower;
      readData[`SAPG_STAT_RUN_BIT]         = (st_r.pwr == sapg_pkg::PWR_RUN);
      readData[`SAPG_STAT_MACRO_BIT]       = st_r.macroOn;
      readData[`SAPG_STAT_BADGAIN_BIT]     = badGain;
    end else if (paddr == `SAPG_COUNT_OFS) begin
      readData[15:0] = st_r.convCount;
    end else begin
      unmapped = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // input synchronisers
    st_nxt.sync1 = {analog_comparator, channel_pin_select, spiClk, rcOsc,
                    routed_external_clock, ringOsc, routedSignals};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prevClk = convClk;
    st_nxt.done = st_r.done & ~tickEdge;

    // apb: one wait state, write lands at the pready edge
    st_nxt.pready = 1'b0;
    if (apbAccess && !st_r.pready) begin
      st_nxt.pready  = 1'b1;
      st_nxt.pslverr = unmapped;
      st_nxt.prdata  = pwrite ? 32'h0000_0000 : readData;
    end
    if (apbAccess && st_r.pready && pwrite && paddr == `SAPG_CTRL_OFS) begin
      st_nxt.cfg = pwdata[`SAPG_CTRL_WIDTH-1:0];
    end

    // power sequencing
    case (st_r.pwr)
      sapg_pkg::PWR_OFF: begin
        if (!pdSig) begin
          st_nxt.pwr     = sapg_pkg::PWR_WARM;
          st_nxt.waitCnt = st_r.macroOn ? FAST_CNT : SLOW_CNT;
        end
      end
      sapg_pkg::PWR_WARM: begin
        if (pdSig) begin
          st_nxt.pwr = sapg_pkg::PWR_OFF;
        end else if (st_r.waitCnt == 16'h0000) begin
          st_nxt.pwr     = sapg_pkg::PWR_RUN;
          st_nxt.macroOn = 1'b1;
          st_nxt.tick    = 4'h0;
        end else begin
          st_nxt.waitCnt = st_r.waitCnt - 16'h0001;
        end
      end
      sapg_pkg::PWR_RUN: begin
        if (pdSig) begin
          st_nxt.pwr = sapg_pkg::PWR_OFF;
        end else if (tickEdge) begin
          st_nxt.tick = st_r.tick + 4'h1;
          if (st_r.tick == 4'hF) begin
            st_nxt.ana.dacTrial = 8'h00;
          end
          if (st_r.tick == `SAPG_SAMPLE_END) begin
            st_nxt.sar          = 8'h00;
            st_nxt.ana.dacTrial = 8'h80;
          end
          if (st_r.tick >= `SAPG_SAR_FIRST && st_r.tick <= `SAPG_SAR_LAST) begin
            st_nxt.sar          = st_r.ana.dacTrial & ~(compBit ? 8'h00 : st_r.ana.dacTrial ^ st_r.sar);
            st_nxt.ana.dacTrial = st_nxt.sar | (st_r.ana.dacTrial ^ st_r.sar) >> 1;
          end
          if (st_r.tick >= `SAPG_SER_FIRST && st_r.tick <= `SAPG_SER_LAST) begin
            st_nxt.serial = st_r.sar[3'(4'h7 - (st_r.tick - `SAPG_SER_FIRST))];
          end else begin
            st_nxt.serial = 1'b0;
          end
          if (st_r.tick == `SAPG_PAR_TICK) begin
            st_nxt.parallel  = st_r.sar;
            st_nxt.done      = 1'b1;
            st_nxt.convCount = st_r.convCount + 16'h0001;
          end
        end
      end
      default: begin
        st_nxt.pwr = sapg_pkg::PWR_OFF;
      end
    endcase
    if (st_nxt.pwr != sapg_pkg::PWR_RUN) begin
      st_nxt.parallel     = 8'h00;
      st_nxt.serial       = 1'b0;
      st_nxt.done         = 1'b0;
      st_nxt.ana.dacTrial = 8'h00;
      st_nxt.tick         = 4'h0;
    end
    if (pdSig && !st_r.cfg.fastPon) begin
      st_nxt.macroOn = 1'b0;
    end

    // analog controls
    st_nxt.ana.diffMode    = st_r.cfg.inputMode;
    st_nxt.ana.pseudoMode  = st_r.cfg.inputMode & st_r.cfg.pseudoEn;
    st_nxt.ana.gain        = st_r.cfg.gain;
    st_nxt.ana.posInFirst  = st_r.cfg.twoChanEn ? chanPin : 1'b1;
    st_nxt.ana.adcPower    = (st_nxt.pwr != sapg_pkg::PWR_OFF);
    st_nxt.ana.pgaPower    = st_nxt.ana.adcPower | (st_r.cfg.pgaPowerOn & ~pdSig);
    st_nxt.ana.pgaOutRoute = st_r.cfg.pgaOutEn & ~st_nxt.ana.adcPower;
    st_nxt.ana.outRefEn    = st_nxt.ana.adcPower;
    st_nxt.ana.vrefSel     = st_r.cfg.vrefSel;
    st_nxt.ana.clkSel      = st_r.cfg.clkSel;
    st_nxt.ana.macroPower  = st_nxt.macroOn | st_nxt.ana.adcPower;
    st_nxt.ana.sampleHold  = (st_nxt.pwr == sapg_pkg::PWR_RUN) && (st_nxt.tick <= `SAPG_SAMPLE_END);
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r         <= '0;
      st_r.cfg     <= `SAPG_CTRL_RESET;
      st_r.pwr     <= sapg_pkg::PWR_OFF;
      // synchronisers start at the power-down level, no power blip after reset
      st_r.sync1   <= '1;
      st_r.sync2   <= '1;
      st_r.prevClk <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata          = st_r.prdata;
  assign pready          = st_r.pready;
  assign pslverr         = st_r.pslverr;
  assign anaCtrl         = st_r.ana;
  assign serial_result   = st_r.serial;
  assign parallel_result = st_r.parallel;
  assign convDone        = st_r.done;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_cfg_write;
    apbAccess && st_r.pready && pwrite && paddr == `SAPG_CTRL_OFS;
  endsequence

  sequence s_result_edge;
    tickEdge && st_r.pwr == sapg_pkg::PWR_RUN && !pdSig && st_r.tick == `SAPG_PAR_TICK;
  endsequence

  a_mode_pseudo: assert property (s_cfg_write |-> ##2
      anaCtrl.pseudoMode == ($past(pwdata[`SAPG_CTRL_MODE_BIT], 2) && $past(pwdata[`SAPG_CTRL_PSEUDO_BIT], 2)))
    else $error("pseudo mode not from both bits");

  a_gain_field: assert property (s_cfg_write |-> ##2 anaCtrl.gain == $past(pwdata[`SAPG_CTRL_GAIN_LSB +: 3], 2))
    else $error("gain not applied");

  a_channel_mux: assert property (rstn |=> anaCtrl.posInFirst == (!$past(st_r.cfg.twoChanEn) || $past(chanPin)))
    else $error("positive input select wrong");

  a_route_gated: assert property (anaCtrl.pgaOutRoute |-> !anaCtrl.adcPower)
    else $error("amplifier pin routed while converter on");

  a_pga_power: assert property (anaCtrl.adcPower |-> anaCtrl.pgaPower && anaCtrl.outRefEn)
    else $error("amplifier or reference off with converter on");

  a_pd_down: assert property (pdSig |=> !anaCtrl.adcPower && !convDone)
    else $error("power-down did not stop converter");

  a_macro_gate: assert property (pdSig && !st_r.cfg.fastPon |=> !st_r.macroOn)
    else $error("macrocell stayed on in slow mode");

  a_fast_pon: assert property ((st_r.pwr == sapg_pkg::PWR_WARM) && st_r.macroOn |-> st_r.waitCnt <= FAST_CNT)
    else $error("fast power-on too long");

  a_done_once: assert property (s_result_edge |=> convDone ##1 (convDone || !anaCtrl.adcPower))
    else $error("done pulse missing");

  a_done_clear: assert property (convDone && tickEdge |=> !convDone)
    else $error("done pulse longer than one conversion cycle");

  a_par_hold: assert property (anaCtrl.adcPower && $changed(parallel_result) |-> convDone && !$past(convDone))
    else $error("parallel result changed without result");

  a_serial_window: assert property (serial_result |-> st_r.tick > `SAPG_SER_FIRST && st_r.tick <= 4'hE)
    else $error("serial bit outside its window");

  a_tick_wrap: assert property (st_r.pwr == sapg_pkg::PWR_RUN && tickEdge && !pdSig |=> st_r.tick == $past(st_r.tick) + 4'h1)
    else $error("conversion counter skipped");

endmodule // sapg_adc_ctrl
`default_nettype wire

// ### test/sapg_far_side.sv
// far-side model: conversion clock sources and comparator
// assumes dacTrial is the converter's present trial code
`default_nettype none
module sapg_far_side (
  // trial code and analog level
  input  wire logic [7:0] dacTrial,
  input  wire logic [7:0] level,
  // clock sources
  output logic            ringOsc,
  output logic            rcOsc,
  output logic            extClk,
  output logic            spiClk,
  // comparator decision
  output logic            compOut
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // slow sources keep the sample rate low
  // ----
  initial begin
    ringOsc = 1'b0;
    forever #320 ringOsc = ~ringOsc;
  end
  initial begin
    rcOsc = 1'b0;
    forever #400 rcOsc = ~rcOsc;
  end
  initial begin
    extClk = 1'b0;
    forever #500 extClk = ~extClk;
  end
  // serial port clock idles, no frames here
  assign spiClk = 1'b0;
  // level sits half a step above its code
  assign compOut = ({level, 1'b1} > {dacTrial, 1'b0});
endmodule // sapg_far_side
`default_nettype wire

// ### test/sar_adc_control_and_pga_select_test.sv
// self-checking bench for the converter control block
// assumes the far-side model drives oscillators and comparator
`default_nettype none
module sar_adc_control_and_pga_select_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic chanPin, ringOsc, rcOsc, extClk, spiClk, compOut, serial_result, convDone;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] routedSignals;
  logic [7:0]  parallel_result, level;
  logic [15:0] serHist;
  time         t0, t1;
  sapg_pkg::sapg_ana_type anaCtrl;
  int bad_count, checked;

  sapg_adc_ctrl #(.SLOW_PON_CYC(20), .FAST_PON_CYC(5)) i_dut (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .routedSignals(routedSignals), .ringOsc(ringOsc), .routed_external_clock(extClk),
    .rcOsc(rcOsc), .spiClk(spiClk), .channel_pin_select(chanPin), .analog_comparator(compOut),
    .anaCtrl(anaCtrl), .serial_result(serial_result), .parallel_result(parallel_result),
    .convDone(convDone));
  sapg_far_side i_far (.dacTrial(anaCtrl.dacTrial), .level(level), .ringOsc(ringOsc),
    .rcOsc(rcOsc), .extClk(extClk), .spiClk(spiClk), .compOut(compOut));

  always @(negedge ringOsc) serHist <= {serHist[14:0], serial_result};

  // ----
  // shared tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_level(input logic v);
    for (int n = 0; n < 3000; n++) begin
      if (convDone === v) return;
      @(posedge clk);
    end
    check(32'(convDone), 32'(v));
  endtask
  task automatic wait_done();
    wait_level(1'b0);
    wait_level(1'b1);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----
  // scenarios
  // ----
  task automatic s_regs();
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, 12'h000, 32'hFFFF_FFFF);
    apb(1'b1, 12'h010, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    check({rd[30:0], err}, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0007_FFFF);
  endtask
  task automatic s_config();
    logic [2:0] k;
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      chanPin <= k[0];
      apb(1'b1, 12'h000, {13'h0, k[1:0], 7'h00, k[1:0], 2'b00, k[2], k, k[1], k[0]});
      repeat (5) @(posedge clk);
      check(32'({anaCtrl.diffMode, anaCtrl.pseudoMode}), 32'({k[0], k[0] & k[1]}));
      check(32'(anaCtrl.gain), 32'(k));
      check(32'(anaCtrl.posInFirst), 32'(!k[2] | k[0]));
      check(32'(anaCtrl.vrefSel), 32'(k[1:0]));
      check(32'(anaCtrl.clkSel), 32'(k[1:0]));
    end
  endtask
  task automatic s_convert();
    level <= 8'hA5;
    apb(1'b1, 12'h000, 32'h0000_0044);
    routedSignals[0] <= 1'b0;
    wait_done();
    t0 = $time;
    check(32'(parallel_result), 32'h0000_00A5);
    check(32'(anaCtrl.outRefEn & anaCtrl.pgaPower & anaCtrl.adcPower), 32'h1);
    check(32'(anaCtrl.pgaOutRoute), 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h0000_07A5);
    repeat (4) @(negedge ringOsc);
    #1;
    check(32'(serHist[7:0]), 32'h0000_00A5);
    level <= 8'h3C;
    check(32'(parallel_result), 32'h0000_00A5);
    wait_done();
    t1 = $time;
    check(32'(parallel_result), 32'h0000_003C);
    check(32'((t1 - t0 > 10220) && (t1 - t0 < 10260)), 32'h1);
  endtask
  task automatic s_powerdown();
    int n;
    routedSignals[0] <= 1'b1;
    repeat (6) @(posedge clk);
    check(32'(anaCtrl.adcPower | anaCtrl.pgaPower | anaCtrl.outRefEn | anaCtrl.macroPower), 32'h0);
    check(32'(parallel_result), 32'h0);
    check(32'(anaCtrl.pgaOutRoute), 32'h1);
    apb(1'b1, 12'h000, 32'h0005_0C44);
    routedSignals[3] <= 1'b0;
    wait_done();
    check(32'(parallel_result), 32'h0000_003C);
    routedSignals[3] <= 1'b1;
    repeat (6) @(posedge clk);
    check(32'({anaCtrl.macroPower, anaCtrl.adcPower}), 32'h2);
    routedSignals[3] <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (anaCtrl.sampleHold !== 1'b1 && n < 100);
    check(n, 32'h0000_0009);
    level <= 8'h5A;
    apb(1'b1, 12'h000, 32'h0003_0C44);
    wait_done();
    wait_done();
    check(32'(parallel_result), 32'h0000_005A);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #500000;
    bad_count++;
    wrap_up();
  end
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    routedSignals = '1;
    chanPin = 1'b0;
    level = 8'h00;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    s_regs();
    s_config();
    s_convert();
    s_powerdown();
    wrap_up();
  end
endmodule // sar_adc_control_and_pga_select_test
`default_nettype wire
